// *** serial_master_regs.vh ***
/*
 * register map, field positions, reset values and timing counts for the
 * byte-oriented serial peripheral master.
 * assumes an apb slave port with 32-bit data on a 50 mhz core clock.
 */
// Overview of operation
// - shifting logic runs only while the enable bit is one.
// - writing the transmit register stores the byte and clears transmit-empty.
// - idle shifter takes the byte at once and transmit-empty sets again.
// - a loaded byte shifts out with serial clock while input is sampled.
// - a byte written while busy waits untouched in the holding buffer.
// - after 8 clock pulses the received byte lands and receive-full sets.
// - each byte completion raises the serial interrupt when enabled.
// - at completion a pending byte loads, transmit-empty sets, next cycle starts.
// - cycles run back to back while bytes are pending, else idle.
// - reading the receive register clears receive-full.
// - duplex bit zero gives full duplex, one gives half duplex.
// - polarity plus separate transmit and receive phase bits are provided.
// - bit-order bit zero sends and receives most significant bit first.
// - half duplex with output enable zero keeps the data output disabled.
// - disabled output still clocks the shifter out and samples input.
// - when disabled, clocks gate and data out and clock sit inactive.
// - with auto-read set, a receive read also clears transmit-empty.
// - half duplex with output enable one drives the shifted data.
`ifndef SERIAL_MASTER_REGS_VH
`define SERIAL_MASTER_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define ENABLE_OFS       12'h000
`define CONTROL_OFS      12'h004
`define STATUS_OFS       12'h008
`define TX_DATA_OFS      12'h00C
`define RX_DATA_OFS      12'h010
`define CLK_CTRL_OFS     12'h014
`define CLK_GEN_OFS      12'h018

// ****************************************************************
// control fields
// ****************************************************************
`define CTL_BIT_ORDER    0
`define CTL_DUPLEX       1
`define CTL_BIDIR_OE     2
`define CTL_IRQ_EN       4
`define CTL_AUTO_READ    5
`define CTL_CS_EN        6
`define CTL_WIDTH        7

// ****************************************************************
// status and clock control fields
// ****************************************************************
`define STS_TX_EMPTY     0
`define STS_RX_FULL      1
`define STS_ACTIVE       2
`define CCK_TX_PHASE     0
`define CCK_RX_PHASE     1
`define CCK_POLARITY     2
`define CCK_WIDTH        3

// ****************************************************************
// reset values and timing
// ****************************************************************
`define CONTROL_RST      7'h00
`define CLK_CTRL_RST     3'h0
`define CLK_GEN_RST      8'h02
`define BITS_PER_BYTE    4'h8

`endif

// *** serial_master.v ***
/*
 * byte-oriented serial peripheral master with one holding byte, separate transmit
 * and receive shift registers and an apb register slave.
 * assumes an apb master on core_clk and a slave sampling on its own terms;
 * serial input arrives asynchronously and is synchronised here.
 */
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "serial_master_regs.vh"

module serial_master #(
  parameter ADDR_W = 12
) (
  input  wire              core_clk,
  input  wire              srst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              serial_in_pin,
  output reg               serial_out_pin,
  output reg               serial_out_oe,
  output reg               serial_clk,
  output reg               chip_select_n,
  output reg               serial_irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg                  serial_enable_reg;
  reg [`CTL_WIDTH-1:0] control_reg;
  reg [`CCK_WIDTH-1:0] clk_ctrl_reg;
  reg [7:0]            clk_gen_reg;
  reg [7:0]            tx_data_reg;
  reg [7:0]            rx_data_reg;
  reg                  tx_holding_empty;
  reg                  rx_holding_full;
  reg                  pending_reg;
  reg                  active_reg;
  reg [7:0]            shift_reg;
  reg [7:0]            rx_shift_reg;
  reg [3:0]            bit_count_reg;
  reg                  phase_reg;
  reg [7:0]            div_count_reg;
  reg                  sin_meta_reg;
  reg                  sin_sync_reg;

  wire bit_order_select    = control_reg[`CTL_BIT_ORDER];
  wire duplex_select       = control_reg[`CTL_DUPLEX];
  wire bidir_output_enable = control_reg[`CTL_BIDIR_OE];
  wire transmit_clock_phase = clk_ctrl_reg[`CCK_TX_PHASE];
  wire receive_clock_phase  = clk_ctrl_reg[`CCK_RX_PHASE];
  wire clock_polarity       = clk_ctrl_reg[`CCK_POLARITY];

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [7:0] out_bit_sel;
    input [7:0] val;
    input       lsb_first;
    begin
      out_bit_sel = lsb_first ? {7'h0, val[0]} : {7'h0, val[7]};
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] val;
    input       din;
    input       lsb_first;
    begin
      shift_in = lsb_first ? {din, val[7:1]} : {val[6:0], din};
    end
  endfunction

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire access   = psel && penable && !pready;
  wire wr_evt   = access && pwrite;
  wire rd_evt   = access && !pwrite;
  wire wr_tx    = wr_evt && (paddr == `TX_DATA_OFS);
  wire rd_rx    = rd_evt && (paddr == `RX_DATA_OFS);
  wire mapped   = (paddr == `ENABLE_OFS) || (paddr == `CONTROL_OFS) ||
                  (paddr == `STATUS_OFS) || (paddr == `TX_DATA_OFS) ||
                  (paddr == `RX_DATA_OFS) || (paddr == `CLK_CTRL_OFS) ||
                  (paddr == `CLK_GEN_OFS);

  // ****************************************************************
  // serial timing
  // ****************************************************************
  // tick marks each half period of the serial clock
  wire tick        = serial_enable_reg && active_reg && (div_count_reg == 8'h00);
  wire lead_edge   = tick && !phase_reg;
  wire trail_edge  = tick && phase_reg;
  wire shift_edge  = transmit_clock_phase ? lead_edge : trail_edge;
  wire sample_edge = receive_clock_phase ? trail_edge : lead_edge;
  wire last_pulse  = trail_edge && (bit_count_reg == `BITS_PER_BYTE - 4'h1);
  wire [7:0] rx_next = shift_in(rx_shift_reg, sin_sync_reg, bit_order_select);

  // ****************************************************************
  // synchroniser
  // ****************************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      sin_meta_reg <= 1'b0;
      sin_sync_reg <= 1'b0;
    end else begin
      sin_meta_reg <= serial_in_pin;
      sin_sync_reg <= sin_meta_reg;
    end
  end

  // ****************************************************************
  // bus slave and control registers
  // ****************************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      prdata            <= 32'h0000_0000;
      serial_enable_reg <= 1'b0;
      control_reg       <= `CONTROL_RST;
      clk_ctrl_reg      <= `CLK_CTRL_RST;
      clk_gen_reg       <= `CLK_GEN_RST;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      if (wr_evt) begin
        case (paddr)
          `ENABLE_OFS:   serial_enable_reg <= pwdata[0];
          `CONTROL_OFS:  control_reg <= pwdata[`CTL_WIDTH-1:0];
          `CLK_CTRL_OFS: clk_ctrl_reg <= pwdata[`CCK_WIDTH-1:0];
          `CLK_GEN_OFS:  clk_gen_reg <= pwdata[7:0];
          default: ;
        endcase
      end
      if (rd_evt) begin
        case (paddr)
          `ENABLE_OFS:   prdata <= {31'h0, serial_enable_reg};
          `CONTROL_OFS:  prdata <= {25'h0, control_reg};
          `STATUS_OFS:   prdata <= {29'h0, active_reg, rx_holding_full, tx_holding_empty};
          `TX_DATA_OFS:  prdata <= {24'h0, tx_data_reg};
          `RX_DATA_OFS:  prdata <= {24'h0, rx_data_reg};
          `CLK_CTRL_OFS: prdata <= {29'h0, clk_ctrl_reg};
          `CLK_GEN_OFS:  prdata <= {24'h0, clk_gen_reg};
          default:       prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  // completion and a fresh write in one cycle: the write wins the
  // holding buffer, the load of the old pending byte happens first
  always @(posedge core_clk) begin
    if (srst) begin
      tx_data_reg      <= 8'h00;
      rx_data_reg      <= 8'h00;
      tx_holding_empty <= 1'b1;
      rx_holding_full  <= 1'b0;
      pending_reg      <= 1'b0;
      active_reg       <= 1'b0;
      shift_reg        <= 8'h00;
      rx_shift_reg     <= 8'h00;
      bit_count_reg    <= 4'h0;
      phase_reg        <= 1'b0;
      div_count_reg    <= 8'h00;
      serial_irq       <= 1'b0;
    end else begin
      serial_irq <= 1'b0;
      if (rd_rx) begin
        rx_holding_full <= 1'b0;
        if (control_reg[`CTL_AUTO_READ])
          tx_holding_empty <= 1'b0;
      end
      if (tick)
        div_count_reg <= clk_gen_reg;
      else if (active_reg && serial_enable_reg)
        div_count_reg <= div_count_reg - 8'h01;
      if (tick)
        phase_reg <= ~phase_reg;
      if (shift_edge && !(transmit_clock_phase && bit_count_reg == 4'h0 && !phase_reg))
        shift_reg <= bit_order_select ? {1'b0, shift_reg[7:1]}
                                      : {shift_reg[6:0], 1'b0};
      if (sample_edge)
        rx_shift_reg <= rx_next;
      if (trail_edge)
        bit_count_reg <= bit_count_reg + 4'h1;
      if (last_pulse) begin
        rx_data_reg     <= receive_clock_phase ? rx_next : rx_shift_reg;
        rx_holding_full <= 1'b1;
        serial_irq      <= control_reg[`CTL_IRQ_EN];
        bit_count_reg   <= 4'h0;
        phase_reg       <= 1'b0;
        if (pending_reg) begin
          shift_reg        <= tx_data_reg;
          pending_reg      <= 1'b0;
          tx_holding_empty <= 1'b1;
        end else begin
          active_reg <= 1'b0;
        end
      end
      if (wr_tx) begin
        tx_data_reg <= pwdata[7:0];
        if (!active_reg || (last_pulse && !pending_reg)) begin
          shift_reg        <= pwdata[7:0];
          active_reg       <= 1'b1;
          tx_holding_empty <= 1'b1;
          pending_reg      <= 1'b0;
          bit_count_reg    <= 4'h0;
          phase_reg        <= 1'b0;
          div_count_reg    <= clk_gen_reg;
        end else begin
          pending_reg      <= 1'b1;
          tx_holding_empty <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // idle clock rests at polarity; data out rests low when gated
  always @(posedge core_clk) begin
    if (srst) begin
      serial_out_pin <= 1'b0;
      serial_out_oe  <= 1'b0;
      serial_clk     <= 1'b0;
      chip_select_n  <= 1'b1;
    end else begin
      chip_select_n <= ~control_reg[`CTL_CS_EN];
      if (!serial_enable_reg) begin
        serial_out_pin <= 1'b0;
        serial_clk     <= clock_polarity;
        serial_out_oe  <= 1'b0;
      end else begin
        serial_out_pin <= out_bit_sel(shift_reg, bit_order_select) != 8'h00;
        // half duplex without output enable still shifts, data is lost
        serial_out_oe  <= !duplex_select || bidir_output_enable;
        serial_clk     <= clock_polarity ^ (active_reg && phase_reg);
      end
    end
  end

endmodule

// *** serial_master_asserts.sv ***
/* port checker for serial_master, bound onto every instance.
   assumes a divider of at least 2: half a serial period is three or more core cycles. */
`timescale 1ns/1ns
module serial_master_asserts (
  input wire        core_clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        serial_clk,
  input wire        chip_select_n,
  input wire        serial_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ****************
  // properties
  // ****************
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("stray read data");
  a_irq_pulse: assert property (serial_irq |=> !serial_irq)
    else $error("long interrupt");
  a_reset_state: assert property ($fell(srst) |-> chip_select_n && !serial_clk && !serial_irq)
    else $error("not at reset values");
  a_clk_high: assert property ($rose(serial_clk) |=> serial_clk [*2])
    else $error("short serial clock");
  // select only moves after a register write
  a_cs_by_write: assert property ($changed(chip_select_n) |-> pready || $past(pready))
    else $error("select moved alone");
  cover property (pslverr);
  cover property (serial_irq);
  cover property ($rose(serial_clk));
endmodule

bind serial_master serial_master_asserts chk (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_irq(serial_irq));

// *** serial_slave_model.sv ***
/* behavioural serial slave: answers every byte with reply, msb first.
   assumes clock polarity and both phases at zero. */
`timescale 1ns/1ns
module serial_slave_model (
  input  wire       serial_clk,
  input  wire       serial_out_pin,
  input  wire       chip_select_n,
  input  wire [7:0] reply,
  output reg        serial_in_pin,
  output reg  [7:0] captured
);
  reg [7:0] tx_sh = 8'h00;
  initial captured = 8'h00;
  initial serial_in_pin = 1'b0;
  always @(negedge chip_select_n) begin
    tx_sh = reply;
    serial_in_pin = reply[7];
  end
  // released line: show the inverse so stale data never matches
  always @(posedge chip_select_n) serial_in_pin = ~serial_in_pin;
  always @(posedge serial_clk) if (!chip_select_n) captured <= {captured[6:0], serial_out_pin};
  always @(negedge serial_clk) if (!chip_select_n) begin
    tx_sh = {tx_sh[6:0], tx_sh[7]};
    serial_in_pin = tx_sh[7];
  end
endmodule

// *** serial_master_tb.sv ***
/* self-checking bench for serial_master with a serial slave model.
   assumes a divider of 3 (160 ns serial period); the slave repeats its reply every byte. */
`timescale 1ns/1ns
`include "serial_master_regs.vh"
`define CHK(g, e) \
  begin \
    comparisons = comparisons + 1; \
    if ((g) !== (e)) begin \
      miscompares = miscompares + 1; \
      $display("[FAIL] %0t got %h want %h", $time, g, e); \
    end \
  end
module serial_master_tb;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg         er;
  reg         sclk_d = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [31:0] rd;
  reg  [7:0]  reply = 8'h00;
  wire [31:0] prdata;
  wire [7:0]  cap;
  wire        pready, pslverr, miso, mosi, oe, sclk, cs_n, irq;
  integer     miscompares = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  integer     irqs = 0;
  integer     oe_hi = 0;
  integer     rises = 0;
  integer     base;
  always #10 core_clk = ~core_clk;
  serial_master dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(miso), .serial_out_pin(mosi), .serial_out_oe(oe),
    .serial_clk(sclk), .chip_select_n(cs_n), .serial_irq(irq));
  serial_slave_model slave (.serial_clk(sclk), .serial_out_pin(mosi),
    .chip_select_n(cs_n), .reply(reply), .serial_in_pin(miso), .captured(cap));
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    sclk_d <= sclk;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (oe === 1'b1) oe_hi <= oe_hi + 1;
    if (sclk === 1'b1 && sclk_d === 1'b0) rises <= rises + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // no interrupt in some tests, so completion is seen through status
  task poll;
    begin
      rd = 0;
      while (rd[1] !== 1'b1) apb(0, `STATUS_OFS, 0);
    end
  endtask
  task t_reset;
    begin
      apb(0, `STATUS_OFS, 0);
      `CHK(rd, 32'h0000_0001)
      apb(0, `CLK_GEN_OFS, 0);
      `CHK(rd, 32'h0000_0002)
      apb(0, 12'h01C, 0);
      `CHK(er, 1'b1)
      $display("test reset done");
    end
  endtask
  task t_disabled;
    begin
      apb(1, `TX_DATA_OFS, 32'h5A);
      repeat (80) @(posedge core_clk);
      `CHK(rises, 0)
      `CHK(sclk, 1'b0)
      `CHK(mosi, 1'b0)
      srst <= 1'b1;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      $display("test disabled done");
    end
  endtask
  task t_duplex;
    begin
      reply <= 8'hC3;
      apb(1, `ENABLE_OFS, 1);
      // half period of four core cycles leaves room for the input synchroniser
      apb(1, `CLK_GEN_OFS, 32'h0000_0003);
      apb(1, `CONTROL_OFS, 32'h50);
      apb(1, `TX_DATA_OFS, 32'hA5);
      apb(0, `STATUS_OFS, 0);
      `CHK(rd[0], 1'b1)
      apb(1, `TX_DATA_OFS, 32'h3C);
      apb(0, `STATUS_OFS, 0);
      `CHK(rd[1:0], 2'b00)
      while (irqs < 1) @(posedge core_clk);
      `CHK(cap, 8'hA5)
      apb(0, `STATUS_OFS, 0);
      `CHK(rd[1:0], 2'b11)
      apb(0, `RX_DATA_OFS, 0);
      `CHK(rd, 32'h0000_00C3)
      apb(0, `STATUS_OFS, 0);
      `CHK(rd[1], 1'b0)
      while (irqs < 2) @(posedge core_clk);
      repeat (30) @(posedge core_clk);
      `CHK(cap, 8'h3C)
      `CHK(irqs, 2)
      `CHK(rises, 16)
      apb(0, `RX_DATA_OFS, 0);
      apb(1, `CONTROL_OFS, 0);
      $display("test duplex done");
    end
  endtask
  task t_lsb;
    begin
      reply <= 8'h01;
      apb(1, `CONTROL_OFS, 32'h61);
      apb(1, `TX_DATA_OFS, 32'h80);
      poll;
      `CHK(cap, 8'h01)
      `CHK(irqs, 2)
      apb(0, `RX_DATA_OFS, 0);
      `CHK(rd, 32'h0000_0080)
      apb(0, `STATUS_OFS, 0);
      `CHK(rd[1:0], 2'b00)
      apb(1, `CONTROL_OFS, 0);
      $display("test lsb done");
    end
  endtask
  task t_half;
    begin
      reply <= 8'h96;
      apb(1, `CONTROL_OFS, 32'h42);
      base = oe_hi;
      apb(1, `TX_DATA_OFS, 32'hFF);
      poll;
      `CHK(oe_hi - base, 0)
      apb(0, `RX_DATA_OFS, 0);
      `CHK(rd, 32'h0000_0096)
      apb(1, `CONTROL_OFS, 32'h46);
      apb(1, `TX_DATA_OFS, 32'h69);
      poll;
      `CHK(oe_hi > base, 1'b1)
      `CHK(cap, 8'h69)
      apb(0, `RX_DATA_OFS, 0);
      apb(1, `CONTROL_OFS, 0);
      apb(1, `CLK_CTRL_OFS, 32'h4);
      repeat (5) @(posedge core_clk);
      `CHK(sclk, 1'b1)
      apb(1, `CLK_CTRL_OFS, 0);
      $display("test half done");
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_disabled;
    t_duplex;
    t_lsb;
    t_half;
    stop_test;
  end
endmodule
